//--- design/asr_regs.v
`timescale 1ns/1ns
`include "asr_map.vh"
// Functional notes
// [R1] status bit 7 shows write lock: set by protect, cleared by release
// [R2] status bit 6 sets on checksum error, stays until host writes clear
// [R3] status bit 5 sets on amp low alarm, clears at conversion start
// [R4] status bit 4 sets on amp high alarm, clears at conversion start
// [R5] status bit 3 sets on reference low alarm, clears at conversion start
// [R6] status bit 2 shows new result since last data read, 0 after reset
// [R7] status bit 1 shows clock source, 1 external, 0 internal
// [R8] status bit 0 set by reset, host clears by writing 0
// [R9] rate byte bits 6:3 select output rate, default 20 sps
// [R10] rate byte bits 2:0 select decimation filter, default FIR
// [R11] timing byte at 03h: chop 6:5, mode 4, delay 3:0, reset 01h
// [R12] host writes 0 to reserved bit 7 of both mode bytes
// [R13] chop field selects normal, chopped, two- or four-wire excitation
// [R14] conversion mode bit: 0 continuous, 1 one-shot
// [R15] delay field inserts start delay; codes 1110 and 1111 reserved
// [R16] writes blocked after F2h command, allowed after F5h; reads allowed
module asr_regs (
   input wire clk,
   input wire rstn,
   input wire ce,
   input wire cmd_valid,
   input wire [7:0] cmd_byte,
   input wire wr_en,
   input wire rd_en,
   input wire [4:0] addr,
   input wire [7:0] wr_data,
   input wire checksum_error,
   input wire amp_low_alarm,
   input wire amp_high_alarm,
   input wire vref_low_alarm,
   input wire conv_start,
   input wire conv_done,
   input wire data_read,
   input wire ext_clock_present,
   output reg [7:0] rd_data,
   output reg rd_valid,
   output reg wr_refused,
   output reg [3:0] sample_rate_sel,
   output reg [2:0] filter_sel,
   output reg [1:0] chop_sel,
   output reg conversion_mode_sel,
   output reg [3:0] start_delay_sel
);
   // =====================================================
   // pin synchronisers for alarm and clock detect levels
   wire [3:0] pin_q;
   asr_sync #(
      .WIDTH(4)
   ) u_sync (
      .clk(clk),
      .rstn(rstn),
      .ce(ce),
      .d({ext_clock_present, vref_low_alarm, amp_high_alarm,
         amp_low_alarm}),
      .q(pin_q)
   );
   wire amp_low_s = pin_q[0];
   wire amp_high_s = pin_q[1];
   wire vref_low_s = pin_q[2];
   wire ext_clk_s = pin_q[3];

   // =====================================================
   // state
   localparam NUM_ALARM = 3;
   reg lock_reg;
   reg lock_next;
   reg checksum_error_flag_reg;
   reg checksum_error_flag_next;
   reg new_sample_flag_reg;
   reg new_sample_flag_next;
   reg clock_src_reg;
   reg reset_flag_reg;
   reg reset_flag_next;
   reg [7:0] rate_filter_config_reg;
   reg [7:0] rate_filter_config_next;
   reg [7:0] conversion_timing_config_reg;
   reg [7:0] conversion_timing_config_next;
   reg [7:0] rd_next;
   wire [NUM_ALARM-1:0] alarm_pin_s;
   wire [NUM_ALARM-1:0] alarm_flag_q;

   // =====================================================
   // write decode
   wire wr_ok = wr_en && !lock_reg;
   wire wr_status = wr_ok && (addr == `ASR_ADDR_STATUS);
   wire wr_rate = wr_ok && (addr == `ASR_ADDR_RATE);
   wire wr_timing = wr_ok && (addr == `ASR_ADDR_TIMING);

   // alarm pins in status order: amp low, amp high, reference low
   assign alarm_pin_s = {amp_low_s, amp_high_s, vref_low_s};

   wire [7:0] status_now = {lock_reg, checksum_error_flag_reg,
      alarm_flag_q, new_sample_flag_reg, clock_src_reg, reset_flag_reg};

   // =====================================================
   // read mux, unmapped addresses read zero
   always @* begin
      case (addr)
         `ASR_ADDR_STATUS: begin
            rd_next = status_now;
         end
         `ASR_ADDR_RATE: begin
            rd_next = rate_filter_config_reg;
         end
         `ASR_ADDR_TIMING: begin
            rd_next = conversion_timing_config_reg;
         end
         default: begin
            rd_next = 8'h00;
         end
      endcase
   end

   // =====================================================
   // [R3] [R4] [R5] alarm flags
   // set wins over conversion start; sticky after the pin drops
   genvar k;
   generate
      for (k = 0; k < NUM_ALARM; k = k + 1) begin : g_alarm
         reg flag_reg;
         reg flag_next;
         always @* begin
            flag_next = flag_reg;
            if (alarm_pin_s[k]) begin
               flag_next = 1'b1;
            end else if (conv_start) begin
               flag_next = 1'b0;
            end
         end
         always @(posedge clk or negedge rstn) begin
            if (!rstn) begin
               flag_reg <= 1'b0;
            end else if (ce) begin
               flag_reg <= flag_next;
            end
         end
         assign alarm_flag_q[k] = flag_reg;
      end
   endgenerate

   // =====================================================
   // [R1] [R16] lock commands
   always @* begin
      lock_next = lock_reg;
      if (cmd_valid && cmd_byte == `ASR_CMD_LOCK) begin
         lock_next = 1'b1;
      end else if (cmd_valid && cmd_byte == `ASR_CMD_UNLOCK) begin
         lock_next = 1'b0;
      end
   end

   always @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         lock_reg <= 1'b0;
      end else if (ce) begin
         lock_reg <= lock_next;
      end
   end

   // =====================================================
   // [R16] refuse locked writes
   always @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         wr_refused <= 1'b0;
      end else if (ce) begin
         wr_refused <= wr_en && lock_reg;
      end
   end

   // =====================================================
   // [R2] sticky checksum, set wins
   always @* begin
      checksum_error_flag_next = checksum_error_flag_reg;
      if (checksum_error) begin
         checksum_error_flag_next = 1'b1;
      end else if (wr_status && !wr_data[`ASR_ST_CSUM]) begin
         checksum_error_flag_next = 1'b0;
      end
   end

   always @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         checksum_error_flag_reg <= 1'b0;
      end else if (ce) begin
         checksum_error_flag_reg <= checksum_error_flag_next;
      end
   end

   // =====================================================
   // [R6] new sample since read, set wins
   always @* begin
      new_sample_flag_next = new_sample_flag_reg;
      if (conv_done) begin
         new_sample_flag_next = 1'b1;
      end else if (data_read) begin
         new_sample_flag_next = 1'b0;
      end
   end

   always @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         new_sample_flag_reg <= 1'b0;
      end else if (ce) begin
         new_sample_flag_reg <= new_sample_flag_next;
      end
   end

   // =====================================================
   // [R7] clock source follows detect
   always @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         clock_src_reg <= `ASR_RST_CLK;
      end else if (ce) begin
         clock_src_reg <= ext_clk_s;
      end
   end

   // =====================================================
   // [R8] host clears reset flag
   always @* begin
      reset_flag_next = reset_flag_reg;
      if (wr_status && !wr_data[`ASR_ST_RST]) begin
         reset_flag_next = 1'b0;
      end
   end

   always @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         reset_flag_reg <= 1'b1;
      end else if (ce) begin
         reset_flag_reg <= reset_flag_next;
      end
   end

   // =====================================================
   // [R9] [R10] [R12] rate and filter byte, stored as written
   always @* begin
      rate_filter_config_next = rate_filter_config_reg;
      if (wr_rate) begin
         rate_filter_config_next = wr_data;
      end
   end

   always @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         rate_filter_config_reg <= `ASR_RST_RATE;
      end else if (ce) begin
         rate_filter_config_reg <= rate_filter_config_next;
      end
   end

   // =====================================================
   // [R11] timing byte, stored as written
   always @* begin
      conversion_timing_config_next = conversion_timing_config_reg;
      if (wr_timing) begin
         conversion_timing_config_next = wr_data;
      end
   end

   always @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         conversion_timing_config_reg <= `ASR_RST_TIMING;
      end else if (ce) begin
         conversion_timing_config_reg <= conversion_timing_config_next;
      end
   end

   // =====================================================
   // [R9] [R10] [R13] [R14] [R15] field outputs
   // registered copies, updated with the byte they come from
   always @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         sample_rate_sel <= `ASR_RST_DR;
         filter_sel <= `ASR_RST_FILT;
         chop_sel <= `ASR_RST_CHOP;
         conversion_mode_sel <= `ASR_RST_CONV;
         start_delay_sel <= `ASR_RST_DLY;
      end else if (ce) begin
         sample_rate_sel <=
            rate_filter_config_next[`ASR_RATE_HI:`ASR_RATE_LO];
         filter_sel <=
            rate_filter_config_next[`ASR_FILT_HI:`ASR_FILT_LO];
         chop_sel <=
            conversion_timing_config_next[`ASR_CHOP_HI:`ASR_CHOP_LO];
         conversion_mode_sel <=
            conversion_timing_config_next[`ASR_CONV_BIT];
         start_delay_sel <=
            conversion_timing_config_next[`ASR_DLY_HI:`ASR_DLY_LO];
      end
   end

   // =====================================================
   // [R16] read port, reads allowed while locked
   always @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         rd_data <= 8'h00;
         rd_valid <= 1'b0;
      end else if (ce) begin
         rd_valid <= rd_en;
         if (rd_en) begin
            rd_data <= rd_next;
         end
      end
   end
endmodule // asr_regs

//--- common/asr_map.vh
`ifndef ASR_MAP_VH
`define ASR_MAP_VH
// =====================================================
// register addresses
`define ASR_ADDR_STATUS 5'h01
`define ASR_ADDR_RATE 5'h02
`define ASR_ADDR_TIMING 5'h03
// =====================================================
// reset values
`define ASR_RST_STATUS 8'h01
`define ASR_RST_RATE 8'h24
`define ASR_RST_TIMING 8'h01
`define ASR_RST_DR 4'h4
`define ASR_RST_FILT 3'h4
`define ASR_RST_CHOP 2'h0
`define ASR_RST_CONV 1'b0
`define ASR_RST_DLY 4'h1
`define ASR_RST_CLK 1'b0
// =====================================================
// status bit positions
`define ASR_ST_LOCK 7
`define ASR_ST_CSUM 6
`define ASR_ST_AMPL 5
`define ASR_ST_AMPH 4
`define ASR_ST_VREF 3
`define ASR_ST_NEW 2
`define ASR_ST_CLK 1
`define ASR_ST_RST 0
// =====================================================
// field positions
`define ASR_RATE_HI 6
`define ASR_RATE_LO 3
`define ASR_FILT_HI 2
`define ASR_FILT_LO 0
`define ASR_CHOP_HI 6
`define ASR_CHOP_LO 5
`define ASR_CONV_BIT 4
`define ASR_DLY_HI 3
`define ASR_DLY_LO 0
`define ASR_RSVD_BIT 7
// =====================================================
// field limits and commands
`define ASR_RATE_MAX 4'hC
`define ASR_FILT_MAX 3'h4
`define ASR_DLY_MAX 4'hD
`define ASR_CMD_LOCK 8'hF2
`define ASR_CMD_UNLOCK 8'hF5
`endif

//--- design/asr_sync.v
`timescale 1ns/1ns
// =====================================================
// two flip-flop level synchroniser, one per bit
module asr_sync #(
   parameter WIDTH = 4
) (
   input wire clk,
   input wire rstn,
   input wire ce,
   input wire [WIDTH-1:0] d,
   output wire [WIDTH-1:0] q
);
   genvar i;
   generate
      for (i = 0; i < WIDTH; i = i + 1) begin : g_bit
         reg meta_reg;
         reg out_reg;
         always @(posedge clk or negedge rstn) begin
            if (!rstn) begin
               meta_reg <= 1'b0;
               out_reg <= 1'b0;
            end else if (ce) begin
               meta_reg <= d[i];
               out_reg <= meta_reg;
            end
         end
         assign q[i] = out_reg;
      end
   endgenerate
endmodule // asr_sync

//--- test/asr_chk.sv
`timescale 1ns/1ns
// ==========
// port checker
module asr_chk (
   input wire clk,
   input wire rstn,
   input wire ce,
   input wire cmd_valid,
   input wire [7:0] cmd_byte,
   input wire wr_en,
   input wire rd_en,
   input wire [4:0] addr,
   input wire [7:0] wr_data,
   input wire rd_valid,
   input wire wr_refused,
   input wire [3:0] sample_rate_sel,
   input wire [2:0] filter_sel
);
   default clocking @(posedge clk); endclocking
   default disable iff (!rstn);
   wire wa = wr_en && ce;
   wire ul = cmd_valid && ce && cmd_byte == 8'hF5;
   wire lk = cmd_valid && ce && cmd_byte == 8'hF2;
   AST_RDV: assert property (rd_en && ce |=> rd_valid)
      else $error("read not answered");
   AST_RDN: assert property (!(rd_en && ce) && ce |=> !rd_valid)
      else $error("stray read answer");
   AST_LCK: assert property (lk ##1 wa |=> wr_refused)
      else $error("locked write taken");
   AST_ULK: assert property (ul ##1 wa |=> !wr_refused)
      else $error("open write refused");
   AST_REF: assert property (!wr_en && ce |=> !wr_refused)
      else $error("stray refusal");
   AST_RATE: assert property (ul ##1 (wa && addr == 5'h02)
      |=> sample_rate_sel == $past(wr_data[6:3])) else $error("rate");
   AST_FILT: assert property (ul ##1 (wa && addr == 5'h02)
      |=> filter_sel == $past(wr_data[2:0])) else $error("filter");
   AST_HOLD: assert property (!wa |=>
      $stable({sample_rate_sel, filter_sel})) else $error("field moved");
endmodule // asr_chk
bind asr_regs asr_chk u_chk (.clk, .rstn, .ce, .cmd_valid, .cmd_byte,
   .wr_en, .rd_en, .addr, .wr_data, .rd_valid, .wr_refused,
   .sample_rate_sel, .filter_sel);

//--- test/asr_host.sv
`timescale 1ns/1ns
// ==========
// host controller model
module asr_host (
   input wire clk,
   input wire [7:0] rd_data,
   input wire rd_valid,
   input wire wr_refused,
   output reg cmd_valid = 1'b0,
   output reg [7:0] cmd_byte = 8'h00,
   output reg wr_en = 1'b0,
   output reg rd_en = 1'b0,
   output reg [4:0] addr = 5'h00,
   output reg [7:0] wr_data = 8'h00
);
   task cmd(input [7:0] b);
      begin
         @(negedge clk);
         {cmd_valid, cmd_byte} = {1'b1, b};
         @(negedge clk);
         {cmd_valid, cmd_byte} = {1'b0, ~b};
      end
   endtask
   task xf(input w, input [4:0] a, input [7:0] d, output [7:0] q,
      output f);
      begin
         @(negedge clk);
         {wr_en, rd_en, addr, wr_data} = {w, !w, a, 1'b0, d[6:0]};
         @(negedge clk);
         {q, f} = {rd_data, w ? wr_refused : rd_valid};
         {wr_en, rd_en, addr, wr_data} = {2'b00, ~a, ~wr_data};
      end
   endtask
endmodule // asr_host

//--- test/asr_regs_tb.sv
`timescale 1ns/1ns
// ==========
// testbench
module asr_regs_tb;
   reg clk = 1'b0, rstn = 1'b0, ce = 1'b1, checksum_error = 1'b0;
   reg amp_low_alarm = 1'b0, amp_high_alarm = 1'b0, vref_low_alarm = 1'b0;
   reg conv_start = 1'b0, conv_done = 1'b0, data_read = 1'b0;
   reg ext_clock_present = 1'b0, ok;
   wire [7:0] rd_data, cmd_byte, wr_data;
   wire [4:0] addr;
   wire [3:0] sample_rate_sel, start_delay_sel;
   wire [2:0] filter_sel;
   wire [1:0] chop_sel;
   wire rd_valid, wr_refused, cmd_valid, wr_en, rd_en, conversion_mode_sel;
   integer failures = 0, num_checks = 0, st, rr = 36, tr = 1, i;
   reg [31:0] lf = 32'h89CE6055;
   reg [7:0] v, d;
   asr_regs dut (.clk, .rstn, .ce, .cmd_valid, .cmd_byte, .wr_en, .rd_en,
      .addr, .wr_data, .checksum_error, .amp_low_alarm, .amp_high_alarm,
      .vref_low_alarm, .conv_start, .conv_done, .data_read,
      .ext_clock_present, .rd_data, .rd_valid, .wr_refused,
      .sample_rate_sel, .filter_sel, .chop_sel, .conversion_mode_sel,
      .start_delay_sel);
   asr_host host (.clk, .rd_data, .rd_valid, .wr_refused, .cmd_valid,
      .cmd_byte, .wr_en, .rd_en, .addr, .wr_data);
   task chk(input [7:0] s, input [7:0] e, input [39:0] n);
      begin
         num_checks = num_checks + 1;
         if (s !== e) begin
            failures = failures + 1;
            $display("Error %0s exp %h seen %h", n, e, s);
         end
      end
   endtask
   task rc(input [4:0] a, input [7:0] e);
      begin
         host.xf(1'b0, a, 8'h00, v, ok);
         chk(ok, 1'b1, "valid");
         chk(v, e, "read");
      end
   endtask
   task wrap_up;
      begin
         $display("checks %0d failures %0d", num_checks, failures);
         if (failures == 0 && num_checks > 0)
            $display("ALL CHECKS OK");
         else
            $display("CHECKS NOT OK");
         $finish;
      end
   endtask
   function [31:0] lfsr_next(input [31:0] s);
      begin
         lfsr_next = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
      end
   endfunction
   initial forever #4 clk = ~clk;
   initial begin
      repeat (6) @(negedge clk);
      rstn = 1'b1;
      rc(5'h01, 8'h01);
      rc(5'h02, 8'h24);
      rc(5'h03, 8'h01);
      rc(5'h1F, 8'h00);
      // every field code
      for (i = 0; i < 32; i = i + 1) begin
         d = i[0] ? {1'b0, i[2:1], i[3], i[4:1]} : {1'b0, i[4:1], i[3:1]};
         host.cmd(8'hF5);
         host.xf(1'b1, {4'h1, i[0]}, d, v, ok);
         chk(ok, 1'b0, "refus");
         if (i[0]) tr = d; else rr = d;
         chk({sample_rate_sel, filter_sel}, rr, "rsel");
         chk({chop_sel, conversion_mode_sel, start_delay_sel}, tr,
            "tsel");
         rc({4'h1, i[0]}, d);
      end
      host.cmd(8'hF2);
      host.xf(1'b1, 5'h02, 8'h11, v, ok);
      chk(ok, 1'b1, "refus");
      rc(5'h02, rr);
      rc(5'h01, 8'h81);
      host.cmd(8'hF5);
      rc(5'h01, 8'h01);
      // clock enable low freezes a write
      @(negedge clk);
      ce = 1'b0;
      host.xf(1'b1, 5'h02, 8'h00, v, ok);
      ce = 1'b1;
      chk(ok, 1'b0, "refus");
      chk({sample_rate_sel, filter_sel}, rr, "rsel");
      rc(5'h02, rr);
      lf = lfsr_next(lf);
      checksum_error = 1'b1;
      {amp_low_alarm, amp_high_alarm, vref_low_alarm} = lf[2:0];
      @(negedge clk);
      checksum_error = 1'b0;
      repeat (3) @(negedge clk);
      {amp_low_alarm, amp_high_alarm, vref_low_alarm} = 3'h0;
      st = 8'h41 | lf[2:0] << 3;
      rc(5'h01, st);
      conv_start = 1'b1;
      @(negedge clk);
      conv_start = 1'b0;
      rc(5'h01, 8'h41);
      host.xf(1'b1, 5'h01, 8'h00, v, ok);
      rc(5'h01, 8'h00);
      conv_done = 1'b1;
      @(negedge clk);
      conv_done = 1'b0;
      rc(5'h01, 8'h04);
      data_read = 1'b1;
      @(negedge clk);
      data_read = 1'b0;
      ext_clock_present = 1'b1;
      rc(5'h01, 8'h00);
      rc(5'h01, 8'h02);
      rstn = 1'b0;
      @(negedge clk);
      rstn = 1'b1;
      repeat (3) @(negedge clk);
      rc(5'h01, 8'h03);
      wrap_up;
   end
endmodule // asr_regs_tb
